// [core/mabi_pkg.sv]
// Package for the multiplexed address/data bus interface: constants and carriers
package mabi_pkg;

  // ----------------------------------------------------------------
  // Register map (AXI4-Lite byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;    // Control: read strobe hold, byte order
  localparam logic [3:0] ADDR_STAT = 4'h4;    // Status: reset options, busy
  localparam int CTRL_HOLD_BIT = 0;           // Hold byte strobes inactive on reads
  localparam int CTRL_BIGEND_BIT = 1;         // Big-endian byte ordering
  localparam logic [1:0] CTRL_RESET = 2'h0;   // Control reset value
  localparam logic [1:0] RESP_OKAY = 2'h0;    // AXI okay answer
  localparam logic [1:0] RESP_SLVERR = 2'h2;  // AXI answer for unmapped address

  // ----------------------------------------------------------------
  // Port widths and datum sizes
  // ----------------------------------------------------------------
  localparam logic [1:0] PORT_W32 = 2'h0;     // 32-bit memory port
  localparam logic [1:0] PORT_W16 = 2'h1;     // 16-bit memory port
  localparam logic [1:0] PORT_W8 = 2'h2;      // 8-bit memory port
  localparam logic [1:0] SIZE_BYTE = 2'h0;    // Byte datum
  localparam logic [1:0] SIZE_HALF = 2'h1;    // Halfword datum
  localparam logic [1:0] SIZE_WORD = 2'h2;    // Word datum
  localparam logic [3:0] STROBES_OFF = 4'hf;  // All byte strobes inactive
  localparam logic [2:0] BURST_WORDS = 3'h4;  // Words in a burst read

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // One transfer request from the core
  typedef struct packed {
    logic [31:0] addr;    // Full byte address
    logic [31:0] wdata;   // Store data, right aligned
    logic [1:0] size;     // Datum size
    logic [1:0] portW;    // Width of addressed memory port
    logic write;          // Write when set
    logic burst;          // Four-word read when set
    logic cacheMiss;      // Read caused by cache miss
    logic instr;          // Instruction reference
  } mabi_req_s;

  // Sampled reset options from the low address pins
  typedef struct packed {
    logic extended_address_hold_option;    // extended_address_hold_option
    logic reserved_high_option;   // reserved_high_option
    logic bootRom8;       // boot_rom_eight_bit_option
    logic bootRom16;      // boot_rom_sixteen_bit_option
  } mabi_opts_s;

  // Bus sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} mabi_state_e;

endpackage : mabi_pkg

// [core/mabi_bus_if.sv]
// Multiplexed address/data bus interface: sequencer, read buffer and register slave
// Functional notes
// (R01) Four active-low byte strobes during address phase
// (R02) Strobes meaningful only for 32-bit ports
// (R03) Control bit holds strobes inactive on reads
// (R04) Latched strobes usable as write enables
// (R05) Address bits 31:4 in address phase
// (R06) Address latch output marks capture time
// (R07) Write phase drives data from write buffer
// (R08) Reads return one datum or four words
// (R09) Lanes chosen by size, port width, ordering; read assembly ignores byte ordering
// (R10) Low address bits valid per port width
// (R11) Single transfers start exact, then increment
// (R12) Burst reads count from zero by width
// (R13) Low address pins sampled as reset options
// (R14) Diagnostic high on cache miss during address
// (R15) Diagnostic high for instruction in data slot
// (R16) Diagnostic undefined outside read cycles
// (R17) Address phase completes before data phase
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps

module mabi_bus_if (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Core request side
  input wire logic reqValid,
  output logic reqReady,
  input wire mabi_pkg::mabi_req_s req,
  // Read data towards the core
  output logic rdValid,
  input wire logic rdReady,
  output logic [31:0] rdData,
  // Shared address/data pins
  input wire logic [31:0] adIn,
  output logic [31:0] adOut,
  output logic adOe,
  // Low address pins
  input wire logic [3:0] lowAddrIn,
  output logic [3:0] lowAddrOut,
  output logic lowAddrOe,
  // Bus control
  output logic addrLatch,
  output logic diag,
  input wire logic memAck,
  // AXI4-Lite slave
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Bytes carried per beat for a port width
  function automatic logic [3:0] stepOf(input logic [1:0] pw);
    case (pw)
      mabi_pkg::PORT_W16: stepOf = 4'h2;
      mabi_pkg::PORT_W8: stepOf = 4'h1;
      default: stepOf = 4'h4;
    endcase
  endfunction : stepOf

  // Bytes in a datum
  function automatic logic [3:0] bytesOf(input logic [1:0] sz);
    case (sz)
      mabi_pkg::SIZE_BYTE: bytesOf = 4'h1;
      mabi_pkg::SIZE_HALF: bytesOf = 4'h2;
      default: bytesOf = 4'h4;
    endcase
  endfunction : bytesOf

  // Lowest byte lane a datum occupies; big-endian mirrors it so strobes and data agree
  function automatic logic [1:0] laneOf(input logic [1:0] sz, a, input logic bigEnd);
    laneOf = bigEnd ? 2'(2'h3 - a - 2'(bytesOf(sz) - 4'h1)) : a;
  endfunction : laneOf

  // Active-low byte strobes for a 32-bit port; lane 3 is bits 31:24
  function automatic logic [3:0] strobesOf(input logic [1:0] sz, input logic [1:0] a,
                                           input logic bigEnd);
    logic [3:0] m;
    m = 4'h0;
    case (sz)
      mabi_pkg::SIZE_BYTE: m = 4'h1 << laneOf(sz, a, bigEnd);
      mabi_pkg::SIZE_HALF: m = 4'h3 << laneOf(sz, a, bigEnd);
      default: m = 4'hf;
    endcase
    strobesOf = ~m;
  endfunction : strobesOf

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mabi_pkg::mabi_state_e st;   // Sequencer state
    mabi_pkg::mabi_req_s cur;    // Transfer in progress
    logic [3:0] low;             // Low address counter
    logic [3:0] left;            // Bytes left of current datum
    logic [2:0] words;           // Burst words left
    logic [31:0] asm_;           // Read assembly word
    logic [31:0] b0;             // Read buffer entry 0
    logic [31:0] b1;             // Read buffer entry 1
    logic [1:0] cnt;             // Buffer occupancy
    logic [1:0] ctrl;            // Control register
    mabi_pkg::mabi_opts_s opts;  // Sampled reset options
    logic [3:0] lowS1;           // Low address pin sync stage 1
    logic [3:0] lowS2;           // Low address pin sync stage 2
    logic [31:0] adS1;           // Bus input sync stage 1
    logic [31:0] adS2;           // Bus input sync stage 2
    logic ackS1;                 // Ack sync stage 1
    logic ackS2;                 // Ack sync stage 2
    logic awHave;                // Write address captured
    logic wHave;                 // Write data captured
    logic [3:0] awA;             // Captured write address
    logic [31:0] wD;             // Captured write data
    logic bV;                    // Write answer pending
    logic [1:0] bR;              // Write answer code
    logic rV;                    // Read answer pending
    logic [31:0] rD;             // Read answer data
    logic [1:0] rR;              // Read answer code
    logic [31:0] adO;            // Bus drive value
    logic adE;                   // Bus drive enable
    logic ale;                   // Address latch output
    logic dg;                    // Diagnostic output
  } mabi_state_s;

  mabi_state_s s_q;  // Registered state
  mabi_state_s s_d;  // Next state

  logic pushW;       // A finished read word enters the buffer
  logic popW;        // Core takes a word
  logic [3:0] step;  // Current beat width in bytes
  logic ackNow;      // Synchronised memory acknowledge

  assign step = stepOf(s_q.cur.portW);
  assign ackNow = s_q.ackS2;
  assign popW = (s_q.cnt != 2'h0) && rdReady;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Whole block in one pass; bus sequencer, buffer and register slave
  always_comb
  begin
    s_d = s_q;
    pushW = 1'b0;
    // Pins from outside pass two flip-flops before use
    s_d.lowS1 = lowAddrIn;
    s_d.lowS2 = s_q.lowS1;
    s_d.adS1 = adIn;
    s_d.adS2 = s_q.adS1;
    s_d.ackS1 = memAck;
    s_d.ackS2 = s_q.ackS1;
    s_d.ale = 1'b0;
    case (s_q.st)
      mabi_pkg::ST_IDLE:
      begin
        // Wait for a request; one cycle of address phase follows
        if (reqValid)
        begin
          s_d.cur = req;
          s_d.st = mabi_pkg::ST_ADDR;
          s_d.adE = 1'b1;
          s_d.ale = 1'b1;                                                  // R06
          s_d.adO[31:4] = req.addr[31:4];                                  // R05
          // Strobes valid only for 32-bit ports; forced off on held reads
          s_d.adO[3:0] = mabi_pkg::STROBES_OFF;                            // R02 R03
          if (req.portW == mabi_pkg::PORT_W32 && (req.write || !s_q.ctrl[mabi_pkg::CTRL_HOLD_BIT]))
            s_d.adO[3:0] = strobesOf(req.size, req.addr[1:0],
                                     s_q.ctrl[mabi_pkg::CTRL_BIGEND_BIT]); // R01 R02 R04
          s_d.dg = req.cacheMiss;                                          // R14 R16
          // Burst counts from zero, single transfers start at target
          s_d.low = req.burst && !req.write ? 4'h0 : req.addr[3:0];        // R11 R12
          s_d.left = bytesOf(req.size);
          s_d.words = mabi_pkg::BURST_WORDS;
          s_d.asm_ = 32'h0;
        end
      end
      mabi_pkg::ST_ADDR:
      begin
        // Address phase finished before data moves                        // R17
        s_d.st = mabi_pkg::ST_DATA;
        s_d.dg = s_q.cur.instr;                                            // R15
        if (s_q.cur.write)
          s_d.adO = s_q.cur.wdata << {laneOf(s_q.cur.size, s_q.low[1:0],
            s_q.ctrl[mabi_pkg::CTRL_BIGEND_BIT]), 3'h0};                   // R07 R09
        else
          s_d.adE = 1'b0;
      end
      mabi_pkg::ST_DATA:
      begin
        // Each acknowledged beat advances the low address, except a read beat while the buffer holds two words
        if (ackNow && (s_q.cur.write || s_q.cnt != 2'h2))
        begin
          s_d.low = 4'(s_q.low + step);                                    // R10 R11 R12
          if (!s_q.cur.write)
            s_d.asm_ = s_q.asm_ | ((s_q.adS2 >> {s_q.low[1:0], 3'h0})
                                    << {2'(s_q.low[1:0] - s_q.cur.addr[1:0]), 3'h0}); // R09
          if (s_q.cur.burst && !s_q.cur.write)
          begin
            // Word complete when the counter crosses a word boundary
            if (s_q.low[1:0] + step[1:0] == 2'h0 || step == 4'h4)
            begin
              pushW = 1'b1;                                                // R08
              s_d.asm_ = 32'h0;
              s_d.words = 3'(s_q.words - 3'h1);
              if (s_q.words == 3'h1)
                s_d.st = mabi_pkg::ST_IDLE;
            end
          end
          else if (s_q.left <= step)
          begin
            pushW = !s_q.cur.write;                                        // R08
            s_d.st = mabi_pkg::ST_IDLE;
            s_d.adE = 1'b0;
          end
          else
          begin
            s_d.left = 4'(s_q.left - step);
            s_d.adO = s_q.cur.wdata >> {4'(bytesOf(s_q.cur.size) - s_q.left + step), 3'h0};
          end
        end
      end
      default: s_d.st = mabi_pkg::ST_IDLE;
    endcase
    // Two-entry read buffer; the sequencer stalls acks when full
    if (popW)
      s_d.b0 = s_q.b1;
    if (pushW)
    begin
      if (s_q.cnt == 2'h0 || (s_q.cnt == 2'h1 && popW))
        s_d.b0 = s_d.st == mabi_pkg::ST_IDLE && !s_q.cur.burst ? s_d.asm_ | s_q.asm_ : s_q.asm_
                 | ((s_q.adS2 >> {s_q.low[1:0], 3'h0}) << {2'(s_q.low[1:0] - s_q.cur.addr[1:0]), 3'h0});
      else
        s_d.b1 = s_q.asm_ | ((s_q.adS2 >> {s_q.low[1:0], 3'h0})
                              << {2'(s_q.low[1:0] - s_q.cur.addr[1:0]), 3'h0});
    end
    s_d.cnt = 2'(s_q.cnt + {1'b0, pushW} - {1'b0, popW});
    // Register slave: write address and data in either order
    if (awvalid && !s_q.awHave)
    begin
      s_d.awHave = 1'b1;
      s_d.awA = awaddr;
    end
    if (wvalid && !s_q.wHave)
    begin
      s_d.wHave = 1'b1;
      s_d.wD = wstrb[0] ? wdata : {30'h0, s_q.ctrl}; // Strobe taken with data; off keeps control
    end
    if (s_q.awHave && s_q.wHave && !s_q.bV)
    begin
      s_d.awHave = 1'b0;
      s_d.wHave = 1'b0;
      s_d.bV = 1'b1;
      s_d.bR = mabi_pkg::RESP_SLVERR;
      if (s_q.awA == mabi_pkg::ADDR_CTRL)
      begin
        s_d.bR = mabi_pkg::RESP_OKAY;
        s_d.ctrl = s_q.wD[1:0];
      end
      else if (s_q.awA == mabi_pkg::ADDR_STAT)
        s_d.bR = mabi_pkg::RESP_OKAY;
    end
    if (s_q.bV && bready)
      s_d.bV = 1'b0;
    // Read channel answers one cycle after the address is taken
    if (arvalid && !s_q.rV)
    begin
      s_d.rV = 1'b1;
      s_d.rR = mabi_pkg::RESP_OKAY;
      if (araddr == mabi_pkg::ADDR_CTRL)
        s_d.rD = {30'h0, s_q.ctrl};
      else if (araddr == mabi_pkg::ADDR_STAT)
        s_d.rD = {27'h0, s_q.st != mabi_pkg::ST_IDLE, s_q.opts};
      else
      begin
        s_d.rD = 32'h0;
        s_d.rR = mabi_pkg::RESP_SLVERR;
      end
    end
    else if (s_q.rV && rready)
      s_d.rV = 1'b0;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset; options keep sampling the pins while reset is held
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.st <= mabi_pkg::ST_IDLE;
      s_q.ctrl <= mabi_pkg::CTRL_RESET;
      s_q.lowS1 <= lowAddrIn;
      s_q.lowS2 <= s_q.lowS1;
      s_q.opts <= s_q.lowS2;                                               // R13
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reqReady = (s_q.st == mabi_pkg::ST_IDLE) && rst_n;
  assign rdValid = s_q.cnt != 2'h0;
  assign rdData = s_q.b0;
  assign adOut = s_q.adO;
  assign adOe = s_q.adE;
  assign lowAddrOut = s_q.low;
  assign lowAddrOe = rst_n;                                                // R13
  assign addrLatch = s_q.ale;
  assign diag = s_q.dg;
  assign awready = !s_q.awHave;
  assign wready = !s_q.wHave;
  assign bvalid = s_q.bV;
  assign bresp = s_q.bR;
  assign arready = !s_q.rV;
  assign rvalid = s_q.rV;
  assign rdata = s_q.rD;
  assign rresp = s_q.rR;

endmodule : mabi_bus_if

// [tb/mabi_bus_if_asserts.sv]
// Checker for the multiplexed bus sequencer, bound to the design's top module
`timescale 1ns/1ps

module mabi_bus_if_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Core request side
  input wire logic reqValid,
  input wire logic reqReady,
  input wire mabi_pkg::mabi_req_s req,
  // Bus pins
  input wire logic [31:0] adOut,
  input wire logic adOe,
  input wire logic [3:0] lowAddrOut,
  input wire logic addrLatch,
  input wire logic diag,
  // Register write answer
  input wire logic bvalid,
  input wire logic bready
);
  // ----------------------------------------------------------------
  // Shared timing
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Request taken by the sequencer
  sequence takeS;
    reqValid && reqReady;
  endsequence
  // Address phase of a read; request fields were sampled one edge back
  sequence latchRdS;
    addrLatch && !$past(req.write);
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  take_to_latch_a: assert property (takeS |=> addrLatch)
    else $error("address latch missing after take");
  latch_pulse_a: assert property (addrLatch |=> !addrLatch)
    else $error("address latch longer than one cycle");
  high_addr_a: assert property (addrLatch |-> adOe && adOut[31:4] == $past(req.addr[31:4]))
    else $error("high address wrong in address phase");
  narrow_off_a: assert property (addrLatch && $past(req.portW) != mabi_pkg::PORT_W32
    |-> adOut[3:0] == mabi_pkg::STROBES_OFF)
    else $error("strobes active for narrow port");
  miss_flag_a: assert property (latchRdS |-> diag == $past(req.cacheMiss))
    else $error("miss flag wrong in address phase");
  instr_flag_a: assert property (latchRdS |=> diag == $past(req.instr, 2))
    else $error("reference kind wrong in second slot");
  wr_drive_a: assert property (addrLatch && $past(req.write) |=> adOe)
    else $error("write data not driven");
  rd_release_a: assert property (latchRdS |=> !adOe)
    else $error("bus not released for read data");
  low_start_a: assert property (addrLatch
    |-> lowAddrOut == ($past(req.burst) && !$past(req.write) ? 4'h0 : $past(req.addr[3:0])))
    else $error("low address start wrong");
  busy_refuse_a: assert property (addrLatch |-> !reqReady)
    else $error("request accepted during transfer");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped early");
endmodule : mabi_bus_if_chk

bind mabi_bus_if mabi_bus_if_chk u_chk (.mclk(mclk), .rst_n(rst_n), .reqValid(reqValid),
  .reqReady(reqReady), .req(req), .adOut(adOut), .adOe(adOe), .lowAddrOut(lowAddrOut),
  .addrLatch(addrLatch), .diag(diag), .bvalid(bvalid), .bready(bready));

// [tb/mabi_mem_model.sv]
// Memory system with address latches facing the multiplexed bus
`timescale 1ns/1ps

module mabi_mem_model (
  // Clock
  input wire logic mclk,
  // Device pins
  input wire logic [31:0] adOut,
  input wire logic adOe,
  input wire logic addrLatch,
  input wire logic diag,
  input wire logic [3:0] lowAddrOut,
  // Bench control: beats to answer, slow answers
  input wire logic [2:0] beats,
  input wire logic slow,
  // Memory drive
  output logic [31:0] adDrv,
  output logic memAck,
  // Captured values
  output logic [31:0] capAd,
  output logic [1:0] capDiag,
  output logic [31:0] capWd,
  output logic [15:0] lowLog
);
  logic [15:0] beatNo; // Read beats served so far

  // ----------------------------------------------------------------
  // Transfer follower
  // ----------------------------------------------------------------
  // Latches on the address pulse, then answers each beat; released lines are inverted
  // so a stale value never passes for fresh read data
  initial
  begin
    memAck = 1'b0;
    adDrv = 32'h0;
    capAd = 32'h0;
    capDiag = 2'h0;
    capWd = 32'h0;
    lowLog = 16'h0;
    beatNo = 16'h0;
    forever
    begin
      @(posedge mclk);
      if (addrLatch === 1'b1)
      begin
        capAd <= adOut;
        capDiag[1] <= diag;
        @(posedge mclk);
        capDiag[0] <= diag;
        for (int i = 0; i < int'(beats); i++)
        begin
          repeat (slow ? 6 : 2) @(posedge mclk);
          lowLog[i*4 +: 4] <= lowAddrOut;
          if (adOe && i == 0) capWd <= adOut;
          if (!adOe)
          begin
            adDrv <= {16'hc0de, beatNo};
            beatNo = beatNo + 16'h1;
          end
          memAck <= 1'b1;
          @(posedge mclk);
          memAck <= 1'b0;
          repeat (2) @(posedge mclk);
          adDrv <= ~adDrv;
        end
      end
    end
  end
endmodule : mabi_mem_model

// [tb/mabi_bus_if_tb.sv]
// Self-checking bench for the multiplexed bus interface
`timescale 1ns/1ps

module mabi_bus_if_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk, rst_n, reqValid, reqReady, rdValid, rdReady, adOe, lowAddrOe, addrLatch, diag;
  logic memAck, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid;
  logic rready, slow;
  logic [31:0] rdData, adIn, adOut, adDrv, wdata, rdata, capAd, capWd;
  logic [3:0] lowAddrIn, lowAddrOut, awaddr, araddr, wstrb, cfgPins;
  logic [1:0] bresp, rresp, capDiag;
  logic [2:0] beats;
  logic [15:0] lowLog, expNo;
  mabi_pkg::mabi_req_s req;
  logic [31:0] rdQ[$]; // Words popped from the read buffer
  int errTotal, testsRun, cycles;

  // Shared pins resolve from the output enables
  assign adIn = adOe ? adOut : adDrv;
  assign lowAddrIn = lowAddrOe ? lowAddrOut : cfgPins;

  mabi_bus_if DUT (.mclk(mclk), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .adIn(adIn),
    .adOut(adOut), .adOe(adOe), .lowAddrIn(lowAddrIn), .lowAddrOut(lowAddrOut),
    .lowAddrOe(lowAddrOe), .addrLatch(addrLatch), .diag(diag), .memAck(memAck),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  mabi_mem_model u_mem (.mclk(mclk), .adOut(adOut), .adOe(adOe), .addrLatch(addrLatch),
    .diag(diag), .lowAddrOut(lowAddrOut), .beats(beats), .slow(slow), .adDrv(adDrv),
    .memAck(memAck), .capAd(capAd), .capDiag(capDiag), .capWd(capWd), .lowLog(lowLog));

  // ----------------------------------------------------------------
  // Clock, read collector, timeout
  // ----------------------------------------------------------------
  always #12.5 mclk = ~mclk;
  // Collects every popped word in order
  always @(posedge mclk)
    if (rst_n && rdValid === 1'b1 && rdReady === 1'b1) rdQ.push_back(rdData);
  // Whole run needs a few hundred cycles; a hang ends here
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errTotal++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      errTotal++;
    end
  endtask : chk

  task axiWr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge mclk);
  endtask : axiWr

  task axiRd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask : axiRd

  function automatic mabi_pkg::mabi_req_s mk(logic [31:0] a, logic [31:0] d, logic [1:0] s,
    logic [1:0] p, logic w, logic b, logic m, logic i);
    return '{a, d, s, p, w, b, m, i};
  endfunction : mk

  // Offers one request, then waits until the sequencer is idle again
  task doReq(input mabi_pkg::mabi_req_s r, input logic [2:0] n);
    beats <= n;
    req <= r;
    reqValid <= 1'b1;
    do @(posedge mclk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    do @(posedge mclk); while (reqReady !== 1'b1);
    repeat (3) @(posedge mclk);
  endtask : doReq

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axiRd(mabi_pkg::ADDR_STAT, d, r);
    chk("reset options", 32'h9, {28'h0, d[3:0]});
    axiRd(mabi_pkg::ADDR_CTRL, d, r);
    chk("ctrl reset", {30'h0, mabi_pkg::CTRL_RESET}, {30'h0, d[1:0]});
    axiRd(4'h8, d, r);
    chk("unmapped read resp", {30'h0, mabi_pkg::RESP_SLVERR}, {30'h0, r});
    axiWr(4'hc, 32'h5, r);
    chk("unmapped write resp", {30'h0, mabi_pkg::RESP_SLVERR}, {30'h0, r});
    $display("test regs done");
  endtask : t_regs

  task t_word;
    doReq(mk(32'h8765_4328, 32'hcafe_f00d, mabi_pkg::SIZE_WORD, mabi_pkg::PORT_W32,
      1'b1, 1'b0, 1'b0, 1'b0), 3'h1);
    chk("word addr phase", 32'h8765_4320, capAd);
    chk("word data", 32'hcafe_f00d, capWd);
    chk("word low addr", 32'h8, {28'h0, lowLog[3:0]});
    $display("test word write done");
  endtask : t_word

  task t_lanes;
    logic [1:0] r;
    for (int o = 0; o < 2; o++)
    begin
      axiWr(mabi_pkg::ADDR_CTRL, {30'h0, o[0], 1'b0}, r);
      doReq(mk(32'h0000_0103, 32'h0000_00a7, mabi_pkg::SIZE_BYTE, mabi_pkg::PORT_W32,
        1'b1, 1'b0, 1'b0, 1'b0), 3'h1);
      chk("byte strobes", o ? 32'he : 32'h7, {28'h0, capAd[3:0]});
      chk("byte lane", 32'ha7, {24'h0, o ? capWd[7:0] : capWd[31:24]});
    end
    axiWr(mabi_pkg::ADDR_CTRL, 32'h0, r);
    $display("test byte lanes done");
  endtask : t_lanes

  task t_narrow;
    doReq(mk(32'h0000_0204, 32'h1122_3344, mabi_pkg::SIZE_WORD, mabi_pkg::PORT_W8,
      1'b1, 1'b0, 1'b0, 1'b0), 3'h4);
    chk("narrow strobes", 32'hf, {28'h0, capAd[3:0]});
    chk("byte port low seq", 32'h7654, {16'h0, lowLog});
    doReq(mk(32'h0000_0208, 32'h5566_7788, mabi_pkg::SIZE_WORD, mabi_pkg::PORT_W16,
      1'b1, 1'b0, 1'b0, 1'b0), 3'h2);
    chk("half port low seq", 32'ha8, {24'h0, lowLog[7:0]});
    $display("test narrow ports done");
  endtask : t_narrow

  task t_burst;
    slow <= 1'b1;
    doReq(mk(32'h0000_3010, 32'h0, mabi_pkg::SIZE_WORD, mabi_pkg::PORT_W32,
      1'b0, 1'b1, 1'b1, 1'b1), 3'h4);
    repeat (6) @(posedge mclk);
    chk("burst low seq", 32'hc840, {16'h0, lowLog});
    chk("burst diag", 32'h3, {30'h0, capDiag});
    chk("burst count", 32'h4, rdQ.size());
    while (rdQ.size() > 0)
    begin
      chk("burst word", {16'hc0de, expNo}, rdQ.pop_front());
      expNo++;
    end
    slow <= 1'b0;
    $display("test burst read done");
  endtask : t_burst

  task t_stall;
    logic [1:0] r;
    axiWr(mabi_pkg::ADDR_CTRL, 32'h1, r);
    rdReady <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      doReq(mk(32'h0000_4000 + 32'(k * 4), 32'h0, mabi_pkg::SIZE_WORD, mabi_pkg::PORT_W32,
        1'b0, 1'b0, 1'b0, 1'b0), 3'h1);
      chk("held strobes", 32'hf, {28'h0, capAd[3:0]});
      chk("data read diag", 32'h0, {30'h0, capDiag});
    end
    chk("buffer holds", 32'h1, {31'h0, rdValid});
    rdReady <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("stall count", 32'h2, rdQ.size());
    while (rdQ.size() > 0)
    begin
      chk("stall word", {16'hc0de, expNo}, rdQ.pop_front());
      expNo++;
    end
    axiWr(mabi_pkg::ADDR_CTRL, 32'h0, r);
    $display("test stall and strobe hold done");
  endtask : t_stall

  task print_verdict;
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {mclk, rst_n, reqValid, awvalid, wvalid, bready, arvalid, rready, slow} = 9'h0;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    req = '0;
    rdReady = 1'b1;
    cfgPins = 4'h9;
    beats = 3'h1;
    expNo = 16'h0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_word();
    t_lanes();
    t_narrow();
    t_burst();
    t_stall();
    print_verdict();
  end
endmodule : mabi_bus_if_tb
